//--- core/crxb_ctrl.sv
// Receive buffer 1 control register, acceptance and interrupt logic
// How it works
// - Mode field chooses which messages are accepted
// - Bit 4 always reads zero
// - Bit 3 shows remote request, read only
// - Filter hit field reports admitting filter code
// - Filter codes 001/000 need buffer0 overflow enable
// - Bit 7 high while buffer holds message
// - Hardware sets full; software clears after reading
module crxb_ctrl (
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_RSTN,
    // Wishbone slave
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [3:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    // Message offered by the receive engine
    input wire logic I_MSG_STB,
    input wire logic I_MSG_VALID,
    input wire logic I_MSG_EXT,
    input wire logic I_MSG_RTR,
    input wire logic [2:0] I_MSG_FILTER,
    input wire logic I_BUFFER0_OVERFLOW_ENABLE,
    output logic O_MSG_TAKEN,
    // Status
    output logic O_BUFFER_FULL_FLAG,
    output logic O_IRQ
);
    import crxb_pkg::*;

    // ****************************************
    // State
    // ****************************************
    logic buffer_full_flag, next_buffer_full_flag;
    logic [1:0] acceptance_mode_field, next_acceptance_mode_field;
    logic remote_request_flag, next_remote_request_flag;
    logic [2:0] filter_hit_field, next_filter_hit_field;
    logic [1:0] irq_stat, next_irq_stat;
    logic [1:0] irq_mask, next_irq_mask;
    logic ack, next_ack;
    logic [31:0] rd_dat, next_rd_dat;
    logic [7:0] ctrl_view;
    logic commit, wr_ctrl, wr_mask, rd_stat;
    logic mode_ok, filter_ok, msg_take, msg_drop;

    // ****************************************
    // Acceptance
    // ****************************************
    always_comb begin
        case (acceptance_mode_field)
            MODE_ANY: mode_ok = 1'b1;
            MODE_EXT: mode_ok = I_MSG_VALID && I_MSG_EXT;
            MODE_STD: mode_ok = I_MSG_VALID && !I_MSG_EXT;
            MODE_ALL_VALID: mode_ok = I_MSG_VALID;
            default: mode_ok = 1'b0;
        endcase
        // Reserved codes are never reported; low codes only via overflow
        filter_ok = (I_MSG_FILTER <= HIT_FILTER_FIVE)
            && ((I_MSG_FILTER >= HIT_FILTER_TWO) || I_BUFFER0_OVERFLOW_ENABLE);
        // A full buffer is never overwritten; the message is dropped instead
        msg_take = I_MSG_STB && mode_ok && filter_ok && !buffer_full_flag;
        msg_drop = I_MSG_STB && mode_ok && filter_ok && buffer_full_flag;
    end

    // ****************************************
    // Bus decode
    // ****************************************
    always_comb begin
        commit = I_WB_CYC && I_WB_STB && ack;
        wr_ctrl = commit && I_WB_WE && I_WB_SEL[0] && (I_WB_ADR == ADR_CTRL);
        wr_mask = commit && I_WB_WE && I_WB_SEL[0] && (I_WB_ADR == ADR_IRQ_MASK);
        rd_stat = commit && !I_WB_WE && (I_WB_ADR == ADR_IRQ_STAT);
        ctrl_view = 8'h00;
        ctrl_view[BIT_FULL] = buffer_full_flag;
        ctrl_view[BIT_MODE_HI:BIT_MODE_LO] = acceptance_mode_field;
        ctrl_view[BIT_UNUSED] = 1'b0;
        ctrl_view[BIT_RTR] = remote_request_flag;
        ctrl_view[BIT_HIT_HI:BIT_HIT_LO] = filter_hit_field;
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_ack = I_WB_CYC && I_WB_STB && !ack;
        next_rd_dat = rd_dat;
        if (next_ack && !I_WB_WE) begin
            case (I_WB_ADR)
                ADR_CTRL: next_rd_dat = {24'h000000, ctrl_view};
                ADR_IRQ_STAT: next_rd_dat = {30'h00000000, irq_stat};
                ADR_IRQ_MASK: next_rd_dat = {30'h00000000, irq_mask};
                default: next_rd_dat = 32'h00000000;
            endcase
        end
        next_acceptance_mode_field = acceptance_mode_field;
        if (wr_ctrl) begin
            next_acceptance_mode_field = I_WB_DAT[BIT_MODE_HI:BIT_MODE_LO];
        end
        // Only a written zero clears; a load in the same cycle wins
        next_buffer_full_flag = buffer_full_flag;
        if (wr_ctrl && !I_WB_DAT[BIT_FULL]) begin
            next_buffer_full_flag = 1'b0;
        end
        if (msg_take) begin
            next_buffer_full_flag = 1'b1;
        end
        // Both captured from the same load, never by software
        next_remote_request_flag = msg_take ? I_MSG_RTR : remote_request_flag;
        next_filter_hit_field = msg_take ? I_MSG_FILTER : filter_hit_field;
        next_irq_mask = wr_mask ? I_WB_DAT[1:0] : irq_mask;
        // Read clears only what it reported; a later or same-cycle event survives
        next_irq_stat = rd_stat ? (irq_stat & ~rd_dat[1:0]) : irq_stat;
        next_irq_stat[BIT_EV_LOAD] = next_irq_stat[BIT_EV_LOAD] | msg_take;
        next_irq_stat[BIT_EV_DROP] = next_irq_stat[BIT_EV_DROP] | msg_drop;
    end

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            buffer_full_flag <= 1'b0;
            acceptance_mode_field <= MODE_RST;
            remote_request_flag <= 1'b0;
            filter_hit_field <= HIT_RST;
            irq_stat <= IRQ_RST;
            irq_mask <= IRQ_RST;
            ack <= 1'b0;
            rd_dat <= 32'h00000000;
        end else begin
            buffer_full_flag <= next_buffer_full_flag;
            acceptance_mode_field <= next_acceptance_mode_field;
            remote_request_flag <= next_remote_request_flag;
            filter_hit_field <= next_filter_hit_field;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            ack <= next_ack;
            rd_dat <= next_rd_dat;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign O_WB_ACK = ack;
    assign O_WB_DAT = rd_dat;
    assign O_MSG_TAKEN = msg_take;
    assign O_BUFFER_FULL_FLAG = buffer_full_flag;
    assign O_IRQ = |(irq_stat & irq_mask);

    // ****************************************
    // Checks
    // ****************************************
    a_mode_ext_only: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        I_MSG_STB && acceptance_mode_field == MODE_EXT && !I_MSG_EXT |-> !O_MSG_TAKEN)
        else $error("extended mode took a standard message");
    a_mode_any: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        I_MSG_STB && acceptance_mode_field == MODE_ANY && filter_ok && !buffer_full_flag
        |-> O_MSG_TAKEN)
        else $error("accept-all mode refused a message");
    a_unused_zero: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        O_WB_ACK && !I_WB_WE && I_WB_ADR == ADR_CTRL |-> O_WB_DAT[BIT_UNUSED] == 1'b0)
        else $error("unused bit read as one");
    a_rtr_loaded: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        O_MSG_TAKEN |=> remote_request_flag == $past(I_MSG_RTR))
        else $error("remote flag not captured");
    a_hit_legal: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        O_MSG_TAKEN |=> filter_hit_field <= HIT_FILTER_FIVE)
        else $error("reserved filter code stored");
    a_low_hit_gate: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        O_MSG_TAKEN && I_MSG_FILTER < HIT_FILTER_TWO |-> I_BUFFER0_OVERFLOW_ENABLE)
        else $error("filter zero or one without overflow enable");
    a_full_on_load: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        O_MSG_TAKEN |=> O_BUFFER_FULL_FLAG ##1 (O_BUFFER_FULL_FLAG || $past(wr_ctrl)))
        else $error("full flag missed a load");
    a_full_clear: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        wr_ctrl && !I_WB_DAT[BIT_FULL] && !O_MSG_TAKEN |=> !O_BUFFER_FULL_FLAG)
        else $error("software clear of full flag lost");
    a_hold_fields: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        !O_MSG_TAKEN |=> $stable(filter_hit_field) && $stable(remote_request_flag))
        else $error("hit or remote flag changed without a load");
    a_ack_pulse: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        O_WB_ACK |=> !O_WB_ACK)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
        else $error("request not acknowledged in one cycle");
    a_mode_std_only: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        I_MSG_STB && acceptance_mode_field == MODE_STD && I_MSG_EXT |-> !O_MSG_TAKEN)
        else $error("standard mode took an extended message");
    a_mode_valid_only: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        I_MSG_STB && acceptance_mode_field != MODE_ANY && !I_MSG_VALID |-> !O_MSG_TAKEN)
        else $error("erroneous message taken outside accept-all mode");
    a_mode_write: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        wr_ctrl |=> acceptance_mode_field == $past(I_WB_DAT[BIT_MODE_HI:BIT_MODE_LO]))
        else $error("mode field write lost");
    a_read_rtr: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        O_WB_ACK && !I_WB_WE && I_WB_ADR == ADR_CTRL |-> O_WB_DAT[BIT_RTR] == $past(remote_request_flag))
        else $error("remote flag read back wrong");
    a_read_hit: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        O_WB_ACK && !I_WB_WE && I_WB_ADR == ADR_CTRL
        |-> O_WB_DAT[BIT_HIT_HI:BIT_HIT_LO] == $past(filter_hit_field))
        else $error("filter hit read back wrong");
    a_low_hit_stored: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        O_MSG_TAKEN && !I_BUFFER0_OVERFLOW_ENABLE |=> filter_hit_field >= HIT_FILTER_TWO)
        else $error("low filter code stored without overflow enable");
    a_read_full: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        O_WB_ACK && !I_WB_WE && I_WB_ADR == ADR_CTRL |-> O_WB_DAT[BIT_FULL] == $past(buffer_full_flag))
        else $error("full flag read back wrong");
    a_full_no_take: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        buffer_full_flag |-> !O_MSG_TAKEN)
        else $error("full buffer overwritten");
    a_full_sticky: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        buffer_full_flag && !(wr_ctrl && !I_WB_DAT[BIT_FULL]) |=> buffer_full_flag)
        else $error("full flag dropped without software clear");
    a_hit_loaded: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        O_MSG_TAKEN |=> filter_hit_field == $past(I_MSG_FILTER))
        else $error("filter hit not captured on load");
    a_load_event: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        O_MSG_TAKEN |=> irq_stat[BIT_EV_LOAD])
        else $error("load event not logged");
    a_drop_event: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        msg_drop |=> irq_stat[BIT_EV_DROP])
        else $error("drop event not logged");
endmodule

//--- inc/crxb_pkg.sv
// Constants for the receive buffer 1 control block
package crxb_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] ADR_CTRL = 4'h0;
    localparam logic [3:0] ADR_IRQ_STAT = 4'h4;
    localparam logic [3:0] ADR_IRQ_MASK = 4'h8;
    // ****************************************
    // Control register fields
    // ****************************************
    localparam int BIT_FULL = 7;
    localparam int BIT_MODE_HI = 6;
    localparam int BIT_MODE_LO = 5;
    localparam int BIT_UNUSED = 4;
    localparam int BIT_RTR = 3;
    localparam int BIT_HIT_HI = 2;
    localparam int BIT_HIT_LO = 0;
    // ****************************************
    // Interrupt status fields
    // ****************************************
    localparam int BIT_EV_LOAD = 0;
    localparam int BIT_EV_DROP = 1;
    // ****************************************
    // Reset values and codes
    // ****************************************
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [2:0] HIT_RST = 3'h0;
    localparam logic [1:0] IRQ_RST = 2'h0;
    localparam logic [1:0] MODE_ALL_VALID = 2'h0;
    localparam logic [1:0] MODE_STD = 2'h1;
    localparam logic [1:0] MODE_EXT = 2'h2;
    localparam logic [1:0] MODE_ANY = 2'h3;
    localparam logic [2:0] HIT_FILTER_TWO = 3'h2;
    localparam logic [2:0] HIT_FILTER_FIVE = 3'h5;
endpackage

//--- testbench/crxb_node.sv
// Far-side node model offering received messages to the buffer
module crxb_node (
    input wire logic clk,
    input wire logic taken,
    output logic stb,
    output logic valid,
    output logic ext,
    output logic rtr,
    output logic [2:0] filt
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        stb = 1'b0;
        {valid, ext, rtr, filt} = 6'h2A;
    end
    // One offer per call; fields inverted afterwards so stale values never match the offer
    task automatic offer(input logic v, e, r, input logic [2:0] f, output logic tk);
        @(posedge clk);
        stb <= 1'b1;
        {valid, ext, rtr, filt} <= {v, e, r, f};
        @(posedge clk);
        tk = taken;
        stb <= 1'b0;
        {valid, ext, rtr, filt} <= ~{v, e, r, f};
    endtask
endmodule

//--- testbench/can_rx_buffer1_control_test.sv
// Register-level bench for the receive buffer 1 control block
module can_rx_buffer1_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    import crxb_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ovf = 1'b0;
    logic [3:0] adr = 4'h0, sel = 4'hF;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic ack, m_stb, m_v, m_e, m_r, taken, full, irq, tk;
    logic [2:0] m_f;
    logic [9:0] tc [12] = '{10'h335, 10'h290, 10'h2D1, 10'h1EC, 10'h1AD, 10'h008,
        10'h0C9, 10'h084, 10'h0A7, 10'h083, 10'h3DE, 10'h398};
    int n_mismatch = 0, samples_checked = 0;
    always #2 clk = ~clk;
    crxb_node node (.clk(clk), .taken(taken), .stb(m_stb), .valid(m_v), .ext(m_e),
        .rtr(m_r), .filt(m_f));
    crxb_ctrl uut (.I_MCLK(clk), .I_RSTN(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
        .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
        .O_WB_ACK(ack), .I_MSG_STB(m_stb), .I_MSG_VALID(m_v), .I_MSG_EXT(m_e),
        .I_MSG_RTR(m_r), .I_MSG_FILTER(m_f), .I_BUFFER0_OVERFLOW_ENABLE(ovf),
        .O_MSG_TAKEN(taken), .O_BUFFER_FULL_FLAG(full), .O_IRQ(irq));
    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    // Classic cycle: hold until ack, then release for one idle cycle
    // No local limit: a missing ack is caught by the watchdog
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask
    task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask
    task automatic results();
        $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd("ctrl", ADR_CTRL, 32'h0);
        rd("unmapped", 4'hC, 32'h0);
        wb(1'b1, ADR_IRQ_MASK, 32'h1);
        rd("mask", ADR_IRQ_MASK, 32'h1);
        $display("test reset done");
        foreach (tc[i]) begin
            wb(1'b1, ADR_CTRL, {24'h0, 1'b0, tc[i][9:8], 5'h0});
            ovf <= tc[i][1];
            node.offer(tc[i][7], tc[i][6], tc[i][5], tc[i][4:2], tk);
            chk("taken", {31'h0, tc[i][0]}, {31'h0, tk});
            if (tc[i][0]) begin
                rd("ctrl", ADR_CTRL, {24'h0, 1'b1, tc[i][9:8], 1'b0, tc[i][5:2]});
                chk("irq", 32'h1, {31'h0, irq});
                rd("status", ADR_IRQ_STAT, 32'h1);
                // Read clear lands at the ack edge; look once it has settled
                @(posedge clk);
                chk("irq", 32'h0, {31'h0, irq});
            end
        end
        rd("ctrl", ADR_CTRL, 32'h60);
        $display("test modes done");
        node.offer(1'b1, 1'b0, 1'b1, 3'h5, tk);
        node.offer(1'b1, 1'b0, 1'b0, 3'h2, tk);
        chk("taken", 32'h0, {31'h0, tk});
        chk("full", 32'h1, {31'h0, full});
        rd("ctrl", ADR_CTRL, 32'hED);
        rd("status", ADR_IRQ_STAT, 32'h3);
        wb(1'b1, ADR_CTRL, 32'h9F);
        rd("ctrl", ADR_CTRL, 32'h8D);
        wb(1'b1, ADR_CTRL, 32'h0);
        rd("ctrl", ADR_CTRL, 32'h0D);
        $display("test full done");
        wb(1'b1, ADR_IRQ_MASK, 32'h0);
        node.offer(1'b1, 1'b0, 1'b0, 3'h3, tk);
        chk("taken", 32'h1, {31'h0, tk});
        @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        rd("ctrl", ADR_CTRL, 32'h83);
        rd("status", ADR_IRQ_STAT, 32'h1);
        $display("test mask done");
        results();
    end
    initial begin
        #20000;
        n_mismatch++;
        results();
    end
endmodule
